// File: hdl/adc_ctrl_pkg.sv
// constants and carrier types for the converter control block
package adc_ctrl_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] MAIN_CFG_ADDR = 4'h0;
    localparam logic [3:0] CAL_ADJ_ADDR = 4'h4;
    localparam logic [3:0] CAL_CONST_ADDR = 4'h5;
    localparam logic [15:0] MAIN_CFG_RESET = 16'h0000;
    localparam logic [15:0] CAL_ADJ_RESET = 16'h4000;

    // field positions
    localparam int TRIM_REQ_BIT = 15;
    localparam int I_PD_BIT = 11;
    localparam int Q_PD_BIT = 10;
    localparam int TRIG_STAMP_BIT = 3;
    localparam int TRIM_SEQ_BIT = 14;
    localparam int CONST_SEL_BIT = 7;
    localparam int TRIM_BUSY_BIT = 0;

    // ----------------------------------------------------------------
    // constant array transfers and timing counts
    // ----------------------------------------------------------------
    localparam int CONST_WORDS = 239;
    localparam logic [7:0] CONST_READS = 8'h0F0;
    localparam logic [7:0] CONST_WRITES = 8'h0F1;
    localparam int FLUSH_CYCLES = 60;
    localparam int TRIM_LOW_MIN_CYCLES = 64;
    localparam int TRIM_HIGH_MIN_CYCLES = 64;
    localparam int DATA_PIPE_STAGES = 4;
    localparam int SAMPLE_W = 12;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SAMPLE_W-1:0] i_out_bus;
        logic [SAMPLE_W-1:0] i_delayed_out_bus;
        logic [SAMPLE_W-1:0] q_out_bus;
        logic [SAMPLE_W-1:0] q_delayed_out_bus;
        logic i_over_range;
        logic q_over_range;
    } out_word_s;

    typedef enum {ST_POWER_WAIT, ST_IDLE, ST_TRIM, ST_FLUSH} ctrl_state_e;

endpackage

// File: hdl/adc_trim_ctrl.sv
// calibration sequencing, time stamp insertion and channel power down
`timescale 1ns/10ps
module adc_trim_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int POWER_ON_WAIT_SHORT_CYCLES = 16777216,
    parameter int POWER_ON_WAIT_LONG_CYCLES = 1073741824,
    parameter int TRIM_FULL_CYCLES = 1400000,
    parameter int TRIM_LINEAR_CYCLES = 1000000
)
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    input wire logic trim_request_in,
    input wire logic power_on_wait_select_in,
    input wire logic i_channel_power_down_in,
    input wire logic q_channel_power_down_in,
    input wire logic extended_control_mode_in,
    input wire logic output_clock_reset_input_in,
    input wire out_word_s conv_word_in,
    output out_word_s data_word_out,
    output logic data_valid_out,
    output logic trim_in_progress_out,
    output logic termination_trim_out,
    output logic output_data_clock_out,
    output logic i_channel_powered_down_out,
    output logic q_channel_powered_down_out
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ctrl_state_e state;
    logic [15:0] main_configuration;
    logic [15:0] calibration_adjust;
    logic [15:0] const_mem [CONST_WORDS];
    logic [7:0] const_idx;
    logic const_sel_q;
    logic [31:0] wait_cnt;
    logic [31:0] trim_cnt;
    logic [31:0] trim_len;
    logic [6:0] flush_cnt;
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;
    logic low_armed;
    logic cmd_start;
    logic first_cycle;
    logic strap_high;
    logic wait_sel_q;
    logic wait_sel_change;
    logic trim_req_eff;
    logic i_pd_eff;
    logic q_pd_eff;
    logic both_down;
    logic trig_meta;
    logic trig_sync;
    logic trig_stamp;
    out_word_s pipe [DATA_PIPE_STAGES];
    out_word_s stamped;
    logic reg_wr_main;
    logic reg_wr_adj;
    logic const_access;

    // ----------------------------------------------------------------
    // control combination
    // ----------------------------------------------------------------
    // pin and register bit are merged only in extended control mode
    assign trim_req_eff = trim_request_in
        | (extended_control_mode_in & main_configuration[TRIM_REQ_BIT]);
    assign i_pd_eff = i_channel_power_down_in
        | (extended_control_mode_in & main_configuration[I_PD_BIT]);
    assign q_pd_eff = q_channel_power_down_in
        | (extended_control_mode_in & main_configuration[Q_PD_BIT]);
    assign both_down = i_pd_eff & q_pd_eff;
    assign wait_sel_change = (power_on_wait_select_in != wait_sel_q)
        && !first_cycle;
    assign reg_wr_main = reg_wr_in && (reg_addr_in == MAIN_CFG_ADDR);
    assign reg_wr_adj = reg_wr_in && (reg_addr_in == CAL_ADJ_ADDR);
    assign const_access = (reg_addr_in == CAL_CONST_ADDR)
        && calibration_adjust[CONST_SEL_BIT];
    // full sequence puts termination ahead of linearity
    assign trim_len = calibration_adjust[TRIM_SEQ_BIT]
        ? 32'(TRIM_FULL_CYCLES) : 32'(TRIM_LINEAR_CYCLES);

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            main_configuration <= MAIN_CFG_RESET;
            calibration_adjust <= CAL_ADJ_RESET;
        end
        else
        begin
            if (reg_wr_main)
                main_configuration <= reg_wdata_in;
            if (reg_wr_adj)
                calibration_adjust <= reg_wdata_in;
        end
    end

    // ----------------------------------------------------------------
    // constant array port
    // ----------------------------------------------------------------
    // a fresh port select sends the index back to the dummy word
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            const_idx <= 8'h00;
            const_sel_q <= 1'b0;
        end
        else
        begin
            const_sel_q <= calibration_adjust[CONST_SEL_BIT];
            if (calibration_adjust[CONST_SEL_BIT] && !const_sel_q)
                const_idx <= 8'h00;
            else if (const_access && reg_rd_in && const_idx < CONST_READS)
                const_idx <= const_idx + 8'h01;
            else if (const_access && reg_wr_in && const_idx < CONST_WRITES)
                const_idx <= const_idx + 8'h01;
        end
    end

    // restore fills words in order; trailing dummy writes dropped
    always_ff @(posedge sys_clk_in)
    begin
        if (const_access && reg_wr_in && const_idx < 8'(CONST_WORDS))
            const_mem[const_idx] <= reg_wdata_in;
    end

    // read data is registered; first read of a save is the dummy word
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                MAIN_CFG_ADDR: reg_rdata_out <= main_configuration;
                CAL_ADJ_ADDR:
                begin
                    reg_rdata_out <= calibration_adjust;
                    reg_rdata_out[TRIM_BUSY_BIT] <= (state == ST_TRIM);
                end
                CAL_CONST_ADDR:
                begin
                    if (const_access && const_idx != 8'h00
                        && const_idx < CONST_READS)
                        reg_rdata_out <= const_mem[const_idx - 8'h01];
                    else
                        reg_rdata_out <= 16'h0000;
                end
                default: reg_rdata_out <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // commanded start detector
    // ----------------------------------------------------------------
    // a full low phase must precede the high count: filters noise
    // and forces the request back low between runs
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            low_cnt <= 8'h00;
            high_cnt <= 8'h00;
            low_armed <= 1'b0;
            cmd_start <= 1'b0;
        end
        else
        begin
            cmd_start <= 1'b0;
            if (!trim_req_eff)
            begin
                high_cnt <= 8'h00;
                if (low_cnt < 8'(TRIM_LOW_MIN_CYCLES - 1))
                    low_cnt <= low_cnt + 8'h01;
                else
                    low_armed <= 1'b1;
            end
            else
            begin
                low_cnt <= 8'h00;
                if (low_armed && high_cnt < 8'(TRIM_HIGH_MIN_CYCLES - 1))
                    high_cnt <= high_cnt + 8'h01;
                else if (low_armed)
                begin
                    cmd_start <= 1'b1;
                    low_armed <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // power-up strap and wait select watch
    // ----------------------------------------------------------------
    // request level is caught on the first clock after reset release
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            first_cycle <= 1'b1;
            strap_high <= 1'b0;
            wait_sel_q <= 1'b0;
        end
        else
        begin
            first_cycle <= 1'b0;
            wait_sel_q <= power_on_wait_select_in;
            if (first_cycle)
                strap_high <= trim_req_eff;
            else if (state != ST_POWER_WAIT)
                strap_high <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // every start path lands in the same trim state and count
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            state <= ST_POWER_WAIT;
            wait_cnt <= 32'h0000_0000;
            trim_cnt <= 32'h0000_0000;
            flush_cnt <= 7'h00;
        end
        else
        begin
            unique case (state)
                ST_POWER_WAIT:
                begin
                    wait_cnt <= wait_cnt + 32'h0000_0001;
                    if (wait_sel_change)
                        wait_cnt <= 32'h0000_0000;
                    else if (wait_cnt >= (power_on_wait_select_in
                        ? 32'(POWER_ON_WAIT_LONG_CYCLES - 1)
                        : 32'(POWER_ON_WAIT_SHORT_CYCLES - 1)))
                    begin
                        trim_cnt <= 32'h0000_0000;
                        // a high request skips the automatic run
                        state <= (strap_high || trim_req_eff)
                            ? ST_IDLE : ST_TRIM;
                    end
                end
                ST_IDLE, ST_FLUSH:
                begin
                    flush_cnt <= flush_cnt + 7'h01;
                    if (state == ST_FLUSH
                        && flush_cnt >= 7'(FLUSH_CYCLES - 1))
                        state <= ST_IDLE;
                    if (cmd_start)
                    begin
                        trim_cnt <= 32'h0000_0000;
                        state <= ST_TRIM;
                    end
                    else if (wait_sel_change)
                    begin
                        wait_cnt <= 32'h0000_0000;
                        state <= ST_POWER_WAIT;
                    end
                end
                ST_TRIM:
                begin
                    flush_cnt <= 7'h00;
                    // both channels down freezes progress in place
                    if (!both_down)
                        trim_cnt <= trim_cnt + 32'h0000_0001;
                    if (!both_down && trim_cnt >= trim_len - 32'h0000_0001)
                        state <= ST_FLUSH;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // status and power outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            trim_in_progress_out <= 1'b0;
            termination_trim_out <= 1'b0;
            i_channel_powered_down_out <= 1'b0;
            q_channel_powered_down_out <= 1'b0;
            output_data_clock_out <= 1'b0;
        end
        else
        begin
            trim_in_progress_out <= (state == ST_TRIM);
            // termination phase leads the full sequence only
            termination_trim_out <= (state == ST_TRIM)
                && calibration_adjust[TRIM_SEQ_BIT]
                && (trim_cnt < 32'(TRIM_FULL_CYCLES - TRIM_LINEAR_CYCLES));
            i_channel_powered_down_out <= i_pd_eff
                | ((state == ST_TRIM) & both_down);
            q_channel_powered_down_out <= q_pd_eff
                | ((state == ST_TRIM) & both_down);
            output_data_clock_out <= !output_data_clock_out;
        end
    end

    // ----------------------------------------------------------------
    // time stamp trigger and data pipeline
    // ----------------------------------------------------------------
    // trigger has no phase relation to the clock, so resync it first
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_stamp <= 1'b0;
        end
        else
        begin
            trig_meta <= output_clock_reset_input_in;
            trig_sync <= trig_meta;
            trig_stamp <= trig_sync;
        end
    end

    // lsb replaced at pipeline entry so it shares the data latency
    always_comb
    begin
        stamped = conv_word_in;
        if (main_configuration[TRIG_STAMP_BIT])
        begin
            stamped.i_out_bus[0] = trig_stamp;
            stamped.i_delayed_out_bus[0] = trig_stamp;
            stamped.q_out_bus[0] = trig_stamp;
            stamped.q_delayed_out_bus[0] = trig_stamp;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            for (int k = 0; k < DATA_PIPE_STAGES; k++)
                pipe[k] <= '0;
        end
        else
        begin
            pipe[0] <= stamped;
            for (int k = 1; k < DATA_PIPE_STAGES; k++)
                pipe[k] <= pipe[k-1];
        end
    end

    // outputs low through trim and flush; a channel that is down
    // shows zero, not stale samples
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            data_word_out <= '0;
            data_valid_out <= 1'b0;
        end
        else
        begin
            data_valid_out <= (state == ST_IDLE);
            if (state != ST_IDLE)
                data_word_out <= '0;
            else
            begin
                data_word_out <= pipe[DATA_PIPE_STAGES-1];
                if (i_pd_eff)
                begin
                    data_word_out.i_out_bus <= '0;
                    data_word_out.i_delayed_out_bus <= '0;
                    data_word_out.i_over_range <= 1'b0;
                end
                if (q_pd_eff)
                begin
                    data_word_out.q_out_bus <= '0;
                    data_word_out.q_delayed_out_bus <= '0;
                    data_word_out.q_over_range <= 1'b0;
                end
            end
        end
    end

endmodule // adc_trim_ctrl

// File: tb/host_trim_model.sv
// host-side model that commands trims on the request pin
`timescale 1ns/10ps
module host_trim_model
(
    input logic sys_clk_in,
    input logic go_in,
    input logic [7:0] low_len_in,
    input logic [7:0] high_len_in,
    output logic trim_request_out = 1'b0,
    output logic busy_out = 1'b0
);
    // idle low, so the power-on trim is not skipped
    logic [7:0] left = 8'h00;
    logic high_phase = 1'b0;

    // low then high phase, lengths from the caller, so a sequence can
    // be short on purpose; a zero high length parks the pin low
    always @(negedge sys_clk_in)
    begin
        if (!busy_out && go_in)
        begin
            busy_out <= 1'b1;
            high_phase <= 1'b0;
            trim_request_out <= 1'b0;
            left <= low_len_in;
        end
        else if (busy_out && left > 8'h01)
            left <= left - 8'h01;
        else if (busy_out && !high_phase)
        begin
            high_phase <= 1'b1;
            trim_request_out <= (high_len_in != 8'h00);
            left <= high_len_in;
        end
        else if (busy_out)
            busy_out <= 1'b0;
    end
endmodule // host_trim_model

// File: tb/adc_trim_ctrl_assertions.sv
// checker watching the trim controller ports
`timescale 1ns/10ps
module adc_trim_ctrl_checker
    import adc_ctrl_pkg::*;
#(
    parameter int TRIM_LINEAR_CYCLES = 100
)
(
    input logic sys_clk_in,
    input logic resetn_in,
    input logic i_channel_power_down_in,
    input logic q_channel_power_down_in,
    input out_word_s data_word_out,
    input logic data_valid_out,
    input logic trim_in_progress_out,
    input logic termination_trim_out,
    input logic output_data_clock_out,
    input logic i_channel_powered_down_out,
    input logic q_channel_powered_down_out
);
    logic [7:0] flush_cnt;
    int tip_len;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    // ----------------------------------------------------------------
    // helper counters
    // ----------------------------------------------------------------
    // cycles since trim ended; saturates so a skipped trim reads ff
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in)
            flush_cnt <= 8'hFF;
        else if (trim_in_progress_out)
            flush_cnt <= 8'h00;
        else if (flush_cnt != 8'hFF)
            flush_cnt <= flush_cnt + 8'h01;
    end

    // trim length, pauses included
    always_ff @(posedge sys_clk_in)
    begin
        if (!resetn_in || !trim_in_progress_out)
            tip_len <= 0;
        else
            tip_len <= tip_len + 1;
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_trim_end;
        $fell(trim_in_progress_out);
    endsequence
    sequence s_flush_quiet;
        (data_word_out == '0 && !data_valid_out) [*8];
    endsequence

    property p_quiet_in_trim;
        trim_in_progress_out && $past(trim_in_progress_out)
            |-> data_word_out == '0;
    endproperty
    a_quiet_in_trim: assert property (p_quiet_in_trim)
        else $error("bus live in trim");
    property p_clock_runs;
        $past(resetn_in)
            |-> output_data_clock_out != $past(output_data_clock_out);
    endproperty
    a_clock_runs: assert property (p_clock_runs)
        else $error("clock stopped");
    property p_no_valid_in_trim;
        trim_in_progress_out |-> !data_valid_out;
    endproperty
    a_no_valid_in_trim: assert property (p_no_valid_in_trim)
        else $error("valid in trim");
    property p_flush_quiet;
        s_trim_end |-> s_flush_quiet;
    endproperty
    a_flush_quiet: assert property (p_flush_quiet)
        else $error("early data");
    property p_flush_len;
        $rose(data_valid_out) && flush_cnt != 8'hFF
            |-> flush_cnt inside {[58:62]};
    endproperty
    a_flush_len: assert property (p_flush_len)
        else $error("bad flush");
    property p_trim_len;
        s_trim_end |-> tip_len >= TRIM_LINEAR_CYCLES;
    endproperty
    a_trim_len: assert property (p_trim_len)
        else $error("short trim");
    property p_term_in_trim;
        termination_trim_out |-> trim_in_progress_out;
    endproperty
    a_term_in_trim: assert property (p_term_in_trim)
        else $error("stray termination");
    property p_i_down;
        $past(resetn_in, 2) && $past(i_channel_power_down_in)
            |-> i_channel_powered_down_out;
    endproperty
    a_i_down: assert property (p_i_down)
        else $error("i not down");
    property p_q_down;
        $past(resetn_in, 2) && $past(q_channel_power_down_in)
            |-> q_channel_powered_down_out;
    endproperty
    a_q_down: assert property (p_q_down)
        else $error("q not down");
    property p_pause;
        trim_in_progress_out && i_channel_power_down_in
            && q_channel_power_down_in |=> trim_in_progress_out;
    endproperty
    a_pause: assert property (p_pause)
        else $error("paused trim ended");
endmodule // adc_trim_ctrl_checker

bind adc_trim_ctrl adc_trim_ctrl_checker
    #(.TRIM_LINEAR_CYCLES(TRIM_LINEAR_CYCLES)) i_chk (
    .sys_clk_in, .resetn_in, .i_channel_power_down_in,
    .q_channel_power_down_in, .data_word_out, .data_valid_out,
    .trim_in_progress_out, .termination_trim_out,
    .output_data_clock_out, .i_channel_powered_down_out,
    .q_channel_powered_down_out
);

// File: tb/adc_trim_ctrl_test.sv
// self-checking bench for the trim controller
`timescale 1ns/10ps
module adc_trim_ctrl_test
    import adc_ctrl_pkg::*;
;
    localparam int LONG_W = 80, FULL_T = 200, LIN_T = 100;
    logic sys_clk = 1'b0;
    logic resetn, reg_wr, reg_rd, wait_sel, i_pd, q_pd, extended_control_mode, trig, go;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [7:0] low_len, high_len;
    logic trim_req, host_busy, valid, tip, term, i_down, q_down;
    logic tip_seen, term_seen;
    out_word_s conv_word, data_word;
    int err_count, tests_run, n;

    adc_trim_ctrl #(.POWER_ON_WAIT_SHORT_CYCLES(50),
        .POWER_ON_WAIT_LONG_CYCLES(LONG_W),
        .TRIM_FULL_CYCLES(FULL_T), .TRIM_LINEAR_CYCLES(LIN_T)) i_dut (
        .sys_clk_in(sys_clk), .resetn_in(resetn), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
        .trim_request_in(trim_req), .power_on_wait_select_in(wait_sel),
        .i_channel_power_down_in(i_pd), .q_channel_power_down_in(q_pd),
        .extended_control_mode_in(extended_control_mode),
        .output_clock_reset_input_in(trig), .conv_word_in(conv_word),
        .data_word_out(data_word), .data_valid_out(valid),
        .trim_in_progress_out(tip), .termination_trim_out(term),
        .output_data_clock_out(), .i_channel_powered_down_out(i_down),
        .q_channel_powered_down_out(q_down));
    host_trim_model i_host (.sys_clk_in(sys_clk), .go_in(go),
        .low_len_in(low_len), .high_len_in(high_len),
        .trim_request_out(trim_req), .busy_out(host_busy));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    always #10 sys_clk = ~sys_clk;

    // sticky flags catch pulses between checks
    always @(negedge sys_clk)
    begin
        tip_seen = tip_seen | tip;
        term_seen = term_seen | term;
    end

    task report_and_stop;
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
        v = reg_rdata;
    endtask
    task cmd(input logic [7:0] lo, input logic [7:0] hi);
        low_len <= lo;
        high_len <= hi;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(2);
        for (int k = 0; k < 600 && host_busy; k++)
            tick(1);
    endtask
    task wait_rise(input int lim);
        for (int k = 0; k < lim && !tip; k++)
            tick(1);
        check(tip, 1);
    endtask
    // trim length in falling edges, then wait for valid
    task trim_len(output int m);
        m = 0;
        while (tip && m < 2000)
        begin
            tick(1);
            m++;
        end
        for (int k = 0; k < 80 && !valid; k++)
            tick(1);
        check(valid, 1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_power_on;
        rd(MAIN_CFG_ADDR, d);
        check(d, MAIN_CFG_RESET);
        rd(CAL_ADJ_ADDR, d);
        check(d, CAL_ADJ_RESET);
        rd(4'h3, d);
        check(d, 0);
        wait_rise(80);
        trim_len(n);
        check(n, FULL_T);
        check(term_seen, 1);
    endtask
    task t_stamp;
        wr(MAIN_CFG_ADDR, 16'h0008);
        tick(12);
        check(data_word[49:2], {4{12'hFFE}});
        trig <= 1'b1;
        n = 0;
        while (!data_word.i_out_bus[0] && n < 20)
        begin
            tick(1);
            n++;
        end
        check(n, 8);
        check(data_word[49:2], {4{12'hFFF}});
        trig <= 1'b0;
        wr(MAIN_CFG_ADDR, 16'h0000);
    endtask
    task t_constants;
        rd(CAL_CONST_ADDR, d);
        check(d, 0);
        wr(CAL_ADJ_ADDR, 16'h4080);
        for (int k = 0; k < CONST_WORDS; k++)
            wr(CAL_CONST_ADDR, 16'h1000 + k[15:0]);
        repeat (2) wr(CAL_CONST_ADDR, 16'h0000);
        wr(CAL_ADJ_ADDR, 16'h4000);
        wr(CAL_ADJ_ADDR, 16'h4080);
        rd(CAL_CONST_ADDR, d);
        check(d, 0);
        for (int k = 0; k < CONST_WORDS; k++)
        begin
            rd(CAL_CONST_ADDR, d);
            check(d, 16'h1000 + k[15:0]);
        end
        wr(CAL_ADJ_ADDR, 16'h4000);
    endtask
    task t_command;
        wr(CAL_ADJ_ADDR, 16'h0000);
        term_seen = 1'b0;
        cmd(64, 64);
        wait_rise(10);
        trim_len(n);
        check(n, LIN_T);
        check(term_seen, 0);
        tip_seen = 1'b0;
        cmd(63, 80);
        tick(20);
        check(tip_seen, 0);
    endtask
    task t_power_down;
        wr(CAL_ADJ_ADDR, 16'h4000);
        i_pd <= 1'b1;
        tick(3);
        check({i_down, q_down}, 2'h2);
        i_pd <= 1'b0;
        extended_control_mode <= 1'b1;
        wr(MAIN_CFG_ADDR, 16'h0400);
        tick(2);
        check({i_down, q_down}, 2'h1);
        wr(MAIN_CFG_ADDR, 16'h0000);
        extended_control_mode <= 1'b0;
        cmd(64, 64);
        wait_rise(10);
        tick(20);
        i_pd <= 1'b1;
        q_pd <= 1'b1;
        tick(50);
        check({tip, i_down, q_down}, 3'h7);
        i_pd <= 1'b0;
        q_pd <= 1'b0;
        trim_len(n);
        check(n, FULL_T - 20);
    endtask
    task t_ext_bit;
        extended_control_mode <= 1'b1;
        cmd(1, 0);
        tick(70);
        wr(MAIN_CFG_ADDR, 16'h8000);
        tick(62);
        wait_rise(20);
        trim_len(n);
        tip_seen = 1'b0;
        cmd(64, 64);
        tick(20);
        check(tip_seen, 0);
        wr(MAIN_CFG_ADDR, 16'h0000);
        extended_control_mode <= 1'b0;
    endtask
    task t_wait_select;
        cmd(1, 0);
        tick(70);
        wait_sel <= 1'b1;
        tick(1);
        wait_rise(LONG_W + 20);
        trim_len(n);
        check(n, FULL_T);
    endtask
    task t_strap;
        cmd(2, 1);
        resetn <= 1'b0;
        tick(6);
        resetn <= 1'b1;
        tip_seen = 1'b0;
        tick(LONG_W + 60);
        check(tip_seen, 0);
        cmd(64, 64);
        wait_rise(10);
        trim_len(n);
        check(n, FULL_T);
    endtask

    // watchdog: some 3800 cycles expected
    initial
    begin
        #(20 * 30000);
        err_count++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        {resetn, reg_wr, reg_rd, wait_sel, i_pd, q_pd, extended_control_mode, trig} = 8'h00;
        {go, tip_seen, term_seen, reg_addr, reg_wdata} = '0;
        {low_len, high_len, err_count, tests_run} = '0;
        conv_word = {{4{12'hFFF}}, 2'h3};
        tick(6);
        resetn <= 1'b1;
        tick(1);
        t_power_on();
        t_stamp();
        t_constants();
        t_command();
        t_power_down();
        t_ext_bit();
        t_wait_select();
        t_strap();
        report_and_stop();
    end
endmodule // adc_trim_ctrl_test
